// ---- ext_memory_model.sv ----
`timescale 1ns/1ps
// external program rom and data ram behind an address latch
module ext_memory_model (
  input wire logic clk,
  input wire logic [7:0] portZeroOut,
  input wire logic [7:0] portZeroOe,
  input wire logic [7:0] portTwoOut,
  input wire logic addressLatchStrobe,
  input wire logic programStoreStrobeN,
  input wire logic dataReadStrobeN,
  input wire logic dataWriteStrobeN,
  output logic [7:0] portZeroIn,
  output logic [15:0] lastAddr,
  output int fetchCount,
  output int busFaults
);
  logic [7:0] lowLatch;
  logic progPrev;
  logic [7:0] ram [0:65535];
  wire logic readN = dataReadStrobeN & programStoreStrobeN;
  wire logic [15:0] busAddr = {portTwoOut, lowLatch};
  initial begin
    portZeroIn = 8'h00;
    lowLatch = 8'h00;
    progPrev = 1'b1;
    lastAddr = 16'h0000;
    fetchCount = 0;
    busFaults = 0;
  end
  // pins sampled on the clock, so strobe and data edges never race
  always @(posedge clk) begin
    if (addressLatchStrobe) lowLatch <= portZeroOut;
    progPrev <= programStoreStrobeN;
    if (!readN) begin
      lastAddr <= busAddr;
      portZeroIn <= programStoreStrobeN ? ram[busAddr] :
        busAddr[7:0] ^ busAddr[15:8] ^ 8'h5a;
    end else begin
      portZeroIn <= ~portZeroIn;
    end
    if (!dataWriteStrobeN) begin
      lastAddr <= busAddr;
      ram[busAddr] <= portZeroOut;
    end
    if (!programStoreStrobeN && progPrev) fetchCount <= fetchCount + 1;
    if (!programStoreStrobeN && portZeroOe !== 8'h00) begin
      busFaults <= busFaults + 1;
    end
  end
endmodule // ext_memory_model

// ---- internal_decode.sv ----
`timescale 1ns/1ps
module internal_decode #(
  parameter logic HAS_UPPER = 1'b1
) (
  input wire logic [7:0] addr,
  input wire logic indirect,
  input wire logic isBitOp,
  input wire logic isBankReg,
  input wire logic [1:0] bankSel,
  output mem_space_pkg::internal_sel_t sel
);
  wire logic [7:0] bankAddr = {3'h0, bankSel, addr[2:0]};
  wire logic [7:0] bitRamByte =
    mem_space_pkg::BIT_AREA_BASE + {4'h0, addr[6:3]};
  wire logic [7:0] bitSfrByte = {addr[7:3], 3'h0};
  wire logic high = addr >= mem_space_pkg::UPPER_BASE;
  wire logic bitHigh = addr >= mem_space_pkg::SFR_BIT_BASE;
  always_comb begin
    sel.isBit = isBitOp;
    sel.bitIndex = isBitOp ? addr[2:0] : 3'h0;
    sel.byteAddr = addr;
    sel.space = mem_space_pkg::SPACE_LOWER;
    if (isBankReg) begin
      sel.byteAddr = bankAddr;
    end else if (isBitOp) begin
      sel.byteAddr = bitHigh ? bitSfrByte : bitRamByte;
      sel.space = bitHigh ? mem_space_pkg::SPACE_SFR
                          : mem_space_pkg::SPACE_LOWER;
    end else if (high && !indirect) begin
      sel.space = mem_space_pkg::SPACE_SFR;
    end else if (high) begin
      sel.space = HAS_UPPER ? mem_space_pkg::SPACE_UPPER
                            : mem_space_pkg::SPACE_NONE;
    end
  end
endmodule // internal_decode

// ---- mcu_memory_space_decoder.sv ----
`timescale 1ns/1ps
module mcu_memory_space_decoder #(
  parameter mem_space_pkg::rom_size_t ROM_SIZE = mem_space_pkg::ROM_4K,
  parameter logic HAS_UPPER = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic externalAccessStrap,
  input wire logic fetchReq,
  input wire logic [15:0] fetchAddr,
  input wire logic intReq,
  input wire logic [1:0] intSrc,
  input wire logic [7:0] romData,
  input wire mem_space_pkg::xdata_req_t xdataReq,
  input wire logic [15:0] dataPointer,
  input wire logic useDataPointer,
  input wire logic [7:0] intAddr,
  input wire logic intIndirect,
  input wire logic intBitOp,
  input wire logic intBankReg,
  input wire logic pswWrite,
  input wire logic [7:0] pswData,
  input wire logic [7:0] portZeroLatch,
  input wire logic [7:0] portTwoLatch,
  input wire logic [7:0] portZeroIn,
  output logic [15:0] romAddr,
  output logic [7:0] codeByte,
  output logic codeValid,
  output logic busy,
  output logic [7:0] xdataRdata,
  output logic xdataDone,
  output logic [7:0] portZeroOut,
  output logic [7:0] portZeroOe,
  output logic [7:0] portTwoOut,
  output logic addressLatchStrobe,
  output logic programStoreStrobeN,
  output logic dataReadStrobeN,
  output logic dataWriteStrobeN,
  output logic [7:0] processorStatusWord,
  output mem_space_pkg::internal_sel_t intSel,
  output logic isInternalFetch
);
  typedef enum logic [2:0] {
    IDLE, ADDR, LATCH, STROBE, SAMPLE
  } bus_state_t;

  bus_state_t state;
  logic strap;
  logic fetchKind;
  logic writeKind;
  logic [15:0] busAddr;
  logic [7:0] busWdata;
  logic keepPortTwo;
  logic firstFetch;
  logic romPending;
  mem_space_pkg::internal_sel_t selNext;

  pin_sync strapSync (
    .clk(clk),
    .nrst(nrst),
    .pin(externalAccessStrap),
    .level(strap)
  );

  internal_decode #(.HAS_UPPER(HAS_UPPER)) decodeUnit (
    .addr(intAddr),
    .indirect(intIndirect),
    .isBitOp(intBitOp),
    .isBankReg(intBankReg),
    .bankSel({processorStatusWord[mem_space_pkg::PSW_BANK_HI],
              processorStatusWord[mem_space_pkg::PSW_BANK_LO]}),
    .sel(selNext)
  );

  wire logic [15:0] reqPc = firstFetch ? mem_space_pkg::RESET_ADDR
                                        : fetchAddr;
  wire logic [15:0] pc = intReq ? mem_space_pkg::vector_addr(intSrc)
                                : reqPc;
  wire logic inRom =
    (ROM_SIZE == mem_space_pkg::ROM_4K) ?
      (pc <= mem_space_pkg::ROM4K_LAST) :
    (ROM_SIZE == mem_space_pkg::ROM_8K) ?
      (pc <= mem_space_pkg::ROM8K_LAST) : 1'b0;
  wire logic internalFetch = strap && inRom;
  // sixteen bits only from the pointer
  wire logic [15:0] xAddr = useDataPointer ? dataPointer
                                           : {8'h00, xdataReq.addr[7:0]};
  wire logic [7:0] pageHigh =
    {portTwoLatch[7:mem_space_pkg::PAGE_BITS],
     xdataReq.addr[mem_space_pkg::PAGE_BITS+7:8]};
  wire logic idle = state == IDLE;
  wire logic startFetch = idle && fetchReq;
  wire logic startData = idle && !fetchReq && xdataReq.valid;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      processorStatusWord <= mem_space_pkg::PSW_RESET;
    end else if (pswWrite) begin
      processorStatusWord <= pswData;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      intSel <= '0;
    end else begin
      intSel <= selNext;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      firstFetch <= 1'b1;
    end else if (startFetch) begin
      firstFetch <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      romPending <= 1'b0;
    end else begin
      romPending <= startFetch && internalFetch;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      romAddr <= mem_space_pkg::RESET_ADDR;
      isInternalFetch <= 1'b0;
    end else if (startFetch) begin
      romAddr <= pc;
      isInternalFetch <= internalFetch;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= IDLE;
      fetchKind <= 1'b0;
      writeKind <= 1'b0;
      busAddr <= 16'h0000;
      busWdata <= 8'h00;
      keepPortTwo <= 1'b0;
    end else begin
      unique case (state)
        IDLE: begin
          if (startFetch && !internalFetch) begin
            state <= ADDR;
            fetchKind <= 1'b1;
            writeKind <= 1'b0;
            busAddr <= pc;
            keepPortTwo <= 1'b0;
          end else if (startData) begin
            state <= ADDR;
            fetchKind <= 1'b0;
            writeKind <= xdataReq.write;
            busWdata <= xdataReq.wdata;
            unique case (xdataReq.mode)
              mem_space_pkg::XADDR_TWO_BYTE: begin
                busAddr <= xAddr;
                keepPortTwo <= !useDataPointer;
              end
              mem_space_pkg::XADDR_PAGED: begin
                busAddr <= {pageHigh, xdataReq.addr[7:0]};
                keepPortTwo <= 1'b0;
              end
              default: begin
                busAddr <= {portTwoLatch, xdataReq.addr[7:0]};
                keepPortTwo <= 1'b1;
              end
            endcase
          end
        end
        ADDR: state <= LATCH;
        LATCH: state <= STROBE;
        STROBE: state <= SAMPLE;
        SAMPLE: state <= IDLE;
        default: state <= IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      portZeroOut <= 8'h00;
      portZeroOe <= 8'h00;
      portTwoOut <= 8'h00;
      addressLatchStrobe <= 1'b0;
      programStoreStrobeN <= 1'b1;
      dataReadStrobeN <= 1'b1;
      dataWriteStrobeN <= 1'b1;
    end else begin
      addressLatchStrobe <= 1'b0;
      programStoreStrobeN <= 1'b1;
      dataReadStrobeN <= 1'b1;
      dataWriteStrobeN <= 1'b1;
      portZeroOut <= portZeroLatch;
      portZeroOe <= 8'hff;
      portTwoOut <= portTwoLatch;
      unique case (state)
        ADDR: begin
          portZeroOut <= busAddr[7:0];
          addressLatchStrobe <= 1'b1;
          portTwoOut <= keepPortTwo ? portTwoLatch : busAddr[15:8];
        end
        LATCH, STROBE: begin
          portZeroOut <= busWdata;
          portZeroOe <= writeKind ? 8'hff : 8'h00;
          portTwoOut <= keepPortTwo ? portTwoLatch : busAddr[15:8];
          programStoreStrobeN <= !fetchKind;
          dataReadStrobeN <= fetchKind || writeKind;
          dataWriteStrobeN <= !writeKind;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      codeByte <= 8'h00;
      codeValid <= 1'b0;
      xdataRdata <= 8'h00;
      xdataDone <= 1'b0;
      busy <= 1'b0;
    end else begin
      codeValid <= 1'b0;
      xdataDone <= 1'b0;
      busy <= !idle || startFetch || startData;
      if (romPending) begin
        codeByte <= romData;
        codeValid <= 1'b1;
      end
      if (state == SAMPLE && fetchKind) begin
        codeByte <= portZeroIn;
        codeValid <= 1'b1;
      end
      if (state == SAMPLE && !fetchKind) begin
        xdataRdata <= writeKind ? busWdata : portZeroIn;
        xdataDone <= 1'b1;
      end
    end
  end

  chk_rom_no_strobe: assert property (
    @(posedge clk) disable iff (!nrst)
    (startFetch && internalFetch) |=> programStoreStrobeN [*4])
    else $error("program strobe during internal fetch");
  chk_fetch_sequence: assert property (
    @(posedge clk) disable iff (!nrst)
    (startFetch && !internalFetch) |-> ##2 addressLatchStrobe
      ##1 (!programStoreStrobeN && portZeroOe == 8'h00))
    else $error("external fetch sequence wrong");
  // data strobes only on data access
  chk_data_strobes: assert property (
    @(posedge clk) disable iff (!nrst)
    (!dataReadStrobeN || !dataWriteStrobeN) |-> (!fetchKind && !idle))
    else $error("data strobe outside data access");
  chk_reset_fetch: assert property (
    @(posedge clk) disable iff (!nrst)
    (startFetch && firstFetch && !intReq)
      |=> romAddr == mem_space_pkg::RESET_ADDR)
    else $error("first fetch not at zero");
  chk_strap_low: assert property (
    @(posedge clk) disable iff (!nrst)
    (startFetch && !strap) |=> !isInternalFetch)
    else $error("fetch internal with strap low");
  chk_sfr_direct: assert property (
    @(posedge clk) disable iff (!nrst)
    (intIndirect && !intBitOp && !intBankReg)
      |=> intSel.space != mem_space_pkg::SPACE_SFR)
    else $error("special space reached indirectly");
  chk_bank_select: assert property (
    @(posedge clk) disable iff (!nrst)
    intBankReg |=> intSel.byteAddr[4:3] ==
      $past({processorStatusWord[mem_space_pkg::PSW_BANK_HI],
             processorStatusWord[mem_space_pkg::PSW_BANK_LO]}))
    else $error("bank select wrong");
  chk_bit_map: assert property (
    @(posedge clk) disable iff (!nrst)
    (intBitOp && !intBankReg && intAddr < mem_space_pkg::SFR_BIT_BASE)
      |=> intSel.byteAddr == mem_space_pkg::BIT_AREA_BASE
        + {4'h0, $past(intAddr[6:3])})
    else $error("bit address mapping wrong");
endmodule // mcu_memory_space_decoder

// ---- mcu_memory_space_decoder_tb.sv ----
`timescale 1ns/1ps
module mcu_memory_space_decoder_tb;
  logic clk, nrst, strap, fetchReq, intReq, useDataPointer;
  logic intIndirect, intBitOp, intBankReg, pswWrite, codeValid, busy;
  logic [1:0] intSrc;
  logic [15:0] fetchAddr, dataPointer, romAddr, lastAddr;
  logic [7:0] intAddr, pswData, portZeroLatch, portTwoLatch, portZeroIn;
  logic [7:0] codeByte, xdataRdata, portZeroOut, portZeroOe, portTwoOut;
  logic [7:0] processor_status_word, got;
  logic ale, progN, rdN, wrN, xdataDone, isInternalFetch;
  mem_space_pkg::xdata_req_t xdataReq;
  mem_space_pkg::internal_sel_t intSel;
  int failures = 0, checksDone = 0, fetchCount, busFaults, n0;
  wire [7:0] romData = romAddr[7:0] ^ romAddr[15:8] ^ 8'ha5;

  mcu_memory_space_decoder mcu_memory_space_decoder_inst (.clk(clk),
    .nrst(nrst), .externalAccessStrap(strap), .fetchReq(fetchReq),
    .fetchAddr(fetchAddr), .intReq(intReq), .intSrc(intSrc),
    .romData(romData), .xdataReq(xdataReq), .dataPointer(dataPointer),
    .useDataPointer(useDataPointer), .intAddr(intAddr),
    .intIndirect(intIndirect), .intBitOp(intBitOp),
    .intBankReg(intBankReg), .pswWrite(pswWrite), .pswData(pswData),
    .portZeroLatch(portZeroLatch), .portTwoLatch(portTwoLatch),
    .portZeroIn(portZeroIn), .romAddr(romAddr), .codeByte(codeByte),
    .codeValid(codeValid), .busy(busy), .xdataRdata(xdataRdata),
    .xdataDone(xdataDone), .portZeroOut(portZeroOut),
    .portZeroOe(portZeroOe), .portTwoOut(portTwoOut),
    .addressLatchStrobe(ale), .programStoreStrobeN(progN),
    .dataReadStrobeN(rdN), .dataWriteStrobeN(wrN),
    .processorStatusWord(processor_status_word), .intSel(intSel),
    .isInternalFetch(isInternalFetch));

  ext_memory_model ext_memory_model_inst (.clk(clk),
    .portZeroOut(portZeroOut),
    .portZeroOe(portZeroOe), .portTwoOut(portTwoOut),
    .addressLatchStrobe(ale), .programStoreStrobeN(progN),
    .dataReadStrobeN(rdN), .dataWriteStrobeN(wrN),
    .portZeroIn(portZeroIn), .lastAddr(lastAddr),
    .fetchCount(fetchCount), .busFaults(busFaults));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (failures == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wait_flag(input logic isData);
    logic flag;
    flag = isData ? xdataDone : codeValid;
    for (int i = 0; i < 20 && flag !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      flag = isData ? xdataDone : codeValid;
    end
    check(flag, 1'b1);
  endtask

  task automatic fetch(input logic [15:0] a, input logic irq,
      input logic [1:0] src);
    @(negedge clk);
    fetchReq = 1'b1;
    fetchAddr = a;
    intReq = irq;
    intSrc = src;
    @(negedge clk);
    fetchReq = 1'b0;
    intReq = 1'b0;
    wait_flag(1'b0);
    got = codeByte;
  endtask

  task automatic xfer(input logic wr, input mem_space_pkg::xaddr_mode_t m,
      input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    xdataReq = '{valid: 1'b1, write: wr, mode: m, addr: a, wdata: d};
    @(negedge clk);
    xdataReq.valid = 1'b0;
    check(busy, 1'b1);
    wait_flag(1'b1);
    got = xdataRdata;
  endtask

  task automatic t_rom_split;
    logic [15:0] list [4] = '{16'h0000, 16'h0fff, 16'h1000, 16'hffff};
    fetch(16'h0abc, 1'b0, 2'h0);
    check(got, 8'ha5);
    foreach (list[i]) begin
      n0 = fetchCount;
      fetch(list[i], 1'b0, 2'h0);
      if (list[i] <= mem_space_pkg::ROM4K_LAST) begin
        check(got, list[i][7:0] ^ list[i][15:8] ^ 8'ha5);
        check(fetchCount - n0, 0);
        check(isInternalFetch, 1'b1);
      end else begin
        check(got, list[i][7:0] ^ list[i][15:8] ^ 8'h5a);
        check(isInternalFetch, 1'b0);
        check(lastAddr, list[i]);
        check(fetchCount - n0, 1);
      end
    end
    check(busFaults, 0);
  endtask

  task automatic t_vectors;
    logic [15:0] v;
    for (int s = 0; s < 4; s++) begin
      v = 16'h0003 + 16'(8 * s);
      fetch(16'h0200, 1'b1, 2'(s));
      check(got, v[7:0] ^ v[15:8] ^ 8'ha5);
    end
  endtask

  task automatic t_xdata;
    n0 = fetchCount;
    xfer(1'b1, mem_space_pkg::XADDR_TWO_BYTE, 16'h4321, 8'ha7);
    check(lastAddr, 16'h3c21);
    xfer(1'b0, mem_space_pkg::XADDR_TWO_BYTE, 16'h4321, 8'h00);
    check(got, 8'ha7);
    xfer(1'b1, mem_space_pkg::XADDR_ONE_BYTE, 16'h0055, 8'h11);
    check(lastAddr, 16'h3c55);
    xfer(1'b1, mem_space_pkg::XADDR_PAGED, 16'h0655, 8'h22);
    check(lastAddr, 16'h3e55);
    xfer(1'b0, mem_space_pkg::XADDR_PAGED, 16'h0655, 8'h00);
    check(got, 8'h22);
    @(negedge clk) useDataPointer = 1'b1;
    xfer(1'b1, mem_space_pkg::XADDR_TWO_BYTE, 16'h0000, 8'h66);
    check(lastAddr, 16'hbeef);
    xfer(1'b0, mem_space_pkg::XADDR_TWO_BYTE, 16'h0000, 8'h00);
    check(got, 8'h66);
    @(negedge clk) useDataPointer = 1'b0;
    check(fetchCount - n0, 0);
  endtask

  task automatic decode(input logic [7:0] a, input logic ind, bo, br,
      input mem_space_pkg::space_t sp, input logic [7:0] b,
      input logic [2:0] bi);
    @(negedge clk);
    {intAddr, intIndirect, intBitOp, intBankReg} = {a, ind, bo, br};
    @(negedge clk);
    check({intSel.space, intSel.byteAddr, intSel.isBit}, {sp, b, bo});
    if (bo) check(intSel.bitIndex, bi);
  endtask

  task automatic t_decode;
    check(processor_status_word, mem_space_pkg::PSW_RESET);
    @(negedge clk);
    pswWrite = 1'b1;
    pswData = 8'h10;
    @(negedge clk);
    pswWrite = 1'b0;
    check(processor_status_word, 8'h10);
    decode(8'h05, 0, 0, 0, mem_space_pkg::SPACE_LOWER, 8'h05, 0);
    decode(8'h05, 1, 0, 0, mem_space_pkg::SPACE_LOWER, 8'h05, 0);
    decode(8'h90, 0, 0, 0, mem_space_pkg::SPACE_SFR, 8'h90, 0);
    decode(8'h90, 1, 0, 0, mem_space_pkg::SPACE_UPPER, 8'h90, 0);
    decode(8'h03, 0, 0, 1, mem_space_pkg::SPACE_LOWER, 8'h13, 0);
    decode(8'h2b, 0, 1, 0, mem_space_pkg::SPACE_LOWER, 8'h25, 3);
    decode(8'h93, 0, 1, 0, mem_space_pkg::SPACE_SFR, 8'h90, 3);
  endtask

  task automatic t_strap_low;
    @(negedge clk);
    strap = 1'b0;
    repeat (6) @(negedge clk);
    n0 = fetchCount;
    fetch(16'h0000, 1'b0, 2'h0);
    check(got, 8'h5a);
    check(fetchCount - n0, 1);
  endtask

  initial begin
    {nrst, fetchReq, intReq, intSrc, fetchAddr, useDataPointer} = '0;
    {intAddr, intIndirect, intBitOp, intBankReg, pswWrite, pswData} = '0;
    xdataReq = '0;
    strap = 1'b1;
    dataPointer = 16'hbeef;
    portZeroLatch = 8'hff;
    portTwoLatch = 8'h3c;
    repeat (8) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_rom_split();
    t_vectors();
    t_xdata();
    t_decode();
    t_strap_low();
    final_report();
  end

  initial begin
    #(25 * 5000);
    failures++;
    final_report();
  end
endmodule // mcu_memory_space_decoder_tb

// ---- mem_space_pkg.sv ----
package mem_space_pkg;
  localparam logic [15:0] RESET_ADDR = 16'h0000;
  localparam logic [15:0] VECTOR_BASE = 16'h0003;
  localparam int VECTOR_SHIFT = 3;
  localparam logic [15:0] ROM4K_LAST = 16'h0fff;
  localparam logic [15:0] ROM8K_LAST = 16'h1fff;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] BIT_AREA_LAST = 8'h2f;
  localparam logic [7:0] BANK_AREA_LAST = 8'h1f;
  localparam logic [7:0] SFR_BIT_BASE = 8'h80;
  localparam int PAGE_BITS = 3;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam int PSW_BANK_HI = 4;
  localparam int PSW_BANK_LO = 3;

  typedef enum logic [1:0] {
    ROM_NONE,
    ROM_4K,
    ROM_8K
  } rom_size_t;

  typedef enum logic [1:0] {
    SPACE_LOWER,
    SPACE_UPPER,
    SPACE_SFR,
    SPACE_NONE
  } space_t;

  typedef enum logic [1:0] {
    XADDR_ONE_BYTE,
    XADDR_TWO_BYTE,
    XADDR_PAGED
  } xaddr_mode_t;

  typedef struct packed {
    logic valid;
    logic write;
    xaddr_mode_t mode;
    logic [15:0] addr;
    logic [7:0] wdata;
  } xdata_req_t;

  typedef struct packed {
    space_t space;
    logic [7:0] byteAddr;
    logic [2:0] bitIndex;
    logic isBit;
  } internal_sel_t;

  function automatic logic [15:0] vector_addr(input logic [1:0] src);
    vector_addr = VECTOR_BASE + {11'h000, src, 3'h0};
  endfunction
endpackage

// ---- pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule // pin_sync
